// ---- hw/pcl_port_config_word_loader.sv ----
// Port configuration word loader: fetches six words from the
// configuration store after reset and holds the per-port fields.
// Assumes the store port runs on the core clock and a classic Wishbone master.
//
// Functional notes
// - Word 54h/56h bit 0 sets keep-state flag of port 2/3.
// - Word bits 3:1 load aux-current field of ports 2 and 3.
// - Word bit 4 loads D1 support bit of ports 2 and 3.
// - Word bit 5 loads D2 support bit of ports 2 and 3.
// - Word bits 7:6 load wake-event support for D2 and D1.
// - High byte of words 55h/57h loads power data byte of port 2/3.
// - Word 60h/62h bit 1 loads connector clock use for port 0/1.
// - Word bit 2 loads device-specific initialization flag, ports 0 and 1.
// - Word bit 3 loads low priority channel count flag, ports 0 and 1.
// - Word bits 6:4 load logical port number, ports 0 and 1.
// - Word bits 15:9 load traffic class to channel 0 map.
// - Word 62h bit 0 marks port 1 slot implemented.
`timescale 1ns/1ps
module pcl_port_config_word_loader
   import pcl_pkg::*;
#(
   parameter int P_ACK_WAIT_CYC = PCL_ACK_WAIT_CYC,
   parameter logic [3:0][15:0] P_IMG_RST = {4{PCL_IMG_RST}}
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // Word store
   output logic o_mem_req,
   output logic [7:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic i_mem_absent,
   input wire logic [15:0] i_mem_data,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // Configuration space fields
   output logic o_cfg_ready,
   output logic [1:0] o_no_soft_reset,
   output logic [5:0] o_aux_current,
   output logic [1:0] o_d1_support,
   output logic [1:0] o_d2_support,
   output logic [3:0] o_pme_support,
   output logic [15:0] o_pm_data,
   output logic o_slot_implemented,
   output logic [1:0] o_slot_clock_cfg,
   output logic [1:0] o_dsi_required,
   output logic [1:0] o_low_priority_channel_count,
   output logic [5:0] o_port_number,
   output logic [13:0] o_tc_vc0_map
);

   localparam int WAIT_W = $clog2(P_ACK_WAIT_CYC + 1);
   localparam logic [WAIT_W-1:0] WAIT_LIMIT = WAIT_W'(P_ACK_WAIT_CYC);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      pcl_ld_t ld;
      logic [2:0] idx;
      logic [WAIT_W-1:0] wait_cnt;
      logic mem_req;
      logic [7:0] mem_addr;
      logic [3:0][15:0] img;
      logic [5:0] skip;
      logic [5:0] absent;
      logic [5:0] tmo;
      logic wb_ack;
      logic [31:0] wb_dat;
   } pcl_state_t;

   pcl_state_t r;
   pcl_state_t next_r;
   logic [1:0] port_sel;
   logic [15:0] word_mask;
   logic wb_req;
   logic [31:0] rd_val;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.wb_ack = 1'b0;
      port_sel = PCL_WORD_PORT[r.idx];
      word_mask = PCL_WORD_MASK[r.idx];
      // Accesses wait out the load so nobody sees half-loaded fields
      wb_req = i_wb_cyc && i_wb_stb && !r.wb_ack && (r.ld == PCL_LD_READY);

      unique case (r.ld)
         PCL_LD_FETCH: begin
            if (!r.mem_req) begin
               if (r.idx > PCL_LAST_IDX) begin
                  next_r.ld = PCL_LD_READY;
               end else if (r.skip[r.idx]) begin
                  next_r.idx = r.idx + 3'h1;
               end else begin
                  next_r.mem_req = 1'b1;
                  next_r.mem_addr = PCL_WORD_ADDR[r.idx];
                  next_r.wait_cnt = '0;
               end
            end else if (i_mem_ack) begin
               next_r.mem_req = 1'b0;
               next_r.idx = r.idx + 3'h1;
               if (i_mem_absent) begin
                  next_r.absent[r.idx] = 1'b1;
               end else begin
                  // Masked merge: high and low bytes of ports 2/3 come from two words
                  next_r.img[port_sel] = (r.img[port_sel] & ~word_mask) |
                     (i_mem_data & word_mask);
               end
            end else if (r.wait_cnt == WAIT_LIMIT) begin
               // Silent store must not hang the switch; word counts as absent
               next_r.mem_req = 1'b0;
               next_r.idx = r.idx + 3'h1;
               next_r.absent[r.idx] = 1'b1;
               next_r.tmo[r.idx] = 1'b1;
            end else begin
               next_r.wait_cnt = r.wait_cnt + 1'b1;
            end
         end
         PCL_LD_READY: begin
            if (wb_req) begin
               next_r.wb_ack = 1'b1;
               if (i_wb_we && i_wb_adr == PCL_REG_CTRL) begin
                  if (i_wb_sel[0]) begin
                     next_r.skip = i_wb_dat[PCL_CTRL_SKIP_LSB +: PCL_WORD_CNT];
                  end
                  if (i_wb_sel[1] && i_wb_dat[PCL_CTRL_RELOAD_BIT]) begin
                     next_r.ld = PCL_LD_FETCH;
                     next_r.idx = '0;
                     next_r.absent = '0;
                     next_r.tmo = '0;
                  end
               end
            end
         end
      endcase

      rd_val = '0;
      unique case (i_wb_adr)
         PCL_REG_CTRL: rd_val[PCL_CTRL_SKIP_LSB +: PCL_WORD_CNT] = r.skip;
         PCL_REG_STATUS: begin
            rd_val[PCL_STAT_BUSY_BIT] = (r.ld == PCL_LD_FETCH);
            rd_val[PCL_STAT_READY_BIT] = (r.ld == PCL_LD_READY);
            rd_val[PCL_STAT_ABSENT_LSB +: PCL_WORD_CNT] = r.absent;
            rd_val[PCL_STAT_TMO_LSB +: PCL_WORD_CNT] = r.tmo;
         end
         PCL_REG_IMG0: rd_val[15:0] = r.img[0];
         PCL_REG_IMG1: rd_val[15:0] = r.img[1];
         PCL_REG_IMG2: rd_val[15:0] = r.img[2];
         PCL_REG_IMG3: rd_val[15:0] = r.img[3];
         default: rd_val = '0;
      endcase
      if (wb_req && !i_wb_we) begin
         next_r.wb_dat = rd_val;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         r.ld <= PCL_LD_FETCH;
         r.idx <= '0;
         r.wait_cnt <= '0;
         r.mem_req <= 1'b0;
         r.mem_addr <= '0;
         r.img <= P_IMG_RST;
         r.skip <= '0;
         r.absent <= '0;
         r.tmo <= '0;
         r.wb_ack <= 1'b0;
         r.wb_dat <= '0;
      end else if (i_clk_en) begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs straight from state flops, except o_cfg_ready, decoded from the load state
   // ------------------------------------------------------------
   assign o_mem_req = r.mem_req;
   assign o_mem_addr = r.mem_addr;
   assign o_wb_ack = r.wb_ack;
   assign o_wb_dat = r.wb_dat;
   assign o_cfg_ready = (r.ld == PCL_LD_READY);

   // Ports 2 and 3: power management fields
   assign o_no_soft_reset = {r.img[3][PCL_NSR_BIT], r.img[2][PCL_NSR_BIT]};
   assign o_aux_current = {r.img[3][PCL_AUX_MSB:PCL_AUX_LSB],
      r.img[2][PCL_AUX_MSB:PCL_AUX_LSB]};
   assign o_d1_support = {r.img[3][PCL_D1_BIT], r.img[2][PCL_D1_BIT]};
   assign o_d2_support = {r.img[3][PCL_D2_BIT], r.img[2][PCL_D2_BIT]};
   assign o_pme_support = {r.img[3][PCL_PME_MSB:PCL_PME_LSB],
      r.img[2][PCL_PME_MSB:PCL_PME_LSB]};
   assign o_pm_data = {r.img[3][PCL_PMD_MSB:PCL_PMD_LSB], r.img[2][PCL_PMD_MSB:PCL_PMD_LSB]};

   // Ports 0 and 1: slot, clock, init, channel and numbering fields
   assign o_slot_implemented = r.img[1][PCL_SLOT_BIT];
   assign o_slot_clock_cfg = {r.img[1][PCL_CLK_BIT], r.img[0][PCL_CLK_BIT]};
   assign o_dsi_required = {r.img[1][PCL_DSI_BIT], r.img[0][PCL_DSI_BIT]};
   assign o_low_priority_channel_count = {r.img[1][PCL_LPC_BIT], r.img[0][PCL_LPC_BIT]};
   assign o_port_number = {r.img[1][PCL_PNUM_MSB:PCL_PNUM_LSB],
      r.img[0][PCL_PNUM_MSB:PCL_PNUM_LSB]};
   assign o_tc_vc0_map = {r.img[1][PCL_TC_MSB:PCL_TC_LSB], r.img[0][PCL_TC_MSB:PCL_TC_LSB]};

endmodule

// ---- hw/pcl_pkg.sv ----
// Constants shared by the port configuration word loader.
// Assumes a 10 MHz core clock and a word store addressed by byte-wide word addresses.
package pcl_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int PCL_CLK_PERIOD_NS = 100;
   // Longest wait for the store to answer one word
   localparam int PCL_ACK_WAIT_NS = 10000;
   localparam int PCL_ACK_WAIT_CYC = (PCL_ACK_WAIT_NS / PCL_CLK_PERIOD_NS < 1) ? 1 :
      PCL_ACK_WAIT_NS / PCL_CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Loader word table, entry 0 listed last
   // ------------------------------------------------------------
   localparam int PCL_WORD_CNT = 6;
   localparam logic [2:0] PCL_LAST_IDX = 3'h5;
   localparam logic [5:0][7:0] PCL_WORD_ADDR = {
      8'h62, 8'h60, 8'h57, 8'h56, 8'h55, 8'h54};
   // Port image that each word lands in
   localparam logic [5:0][1:0] PCL_WORD_PORT = {
      2'h1, 2'h0, 2'h3, 2'h3, 2'h2, 2'h2};
   // Word bits that carry fields; the rest are dropped
   localparam logic [5:0][15:0] PCL_WORD_MASK = {
      16'hfe7f, 16'hfe7e, 16'hff00, 16'h00ff, 16'hff00, 16'h00ff};

   // ------------------------------------------------------------
   // Field positions inside a port image (same as loader word)
   // ------------------------------------------------------------
   localparam int PCL_NSR_BIT = 0;
   localparam int PCL_AUX_LSB = 1;
   localparam int PCL_AUX_MSB = 3;
   localparam int PCL_D1_BIT = 4;
   localparam int PCL_D2_BIT = 5;
   localparam int PCL_PME_LSB = 6;
   localparam int PCL_PME_MSB = 7;
   localparam int PCL_PMD_LSB = 8;
   localparam int PCL_PMD_MSB = 15;
   localparam int PCL_SLOT_BIT = 0;
   localparam int PCL_CLK_BIT = 1;
   localparam int PCL_DSI_BIT = 2;
   localparam int PCL_LPC_BIT = 3;
   localparam int PCL_PNUM_LSB = 4;
   localparam int PCL_PNUM_MSB = 6;
   localparam int PCL_TC_LSB = 9;
   localparam int PCL_TC_MSB = 15;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] PCL_REG_CTRL = 8'h00;
   localparam logic [7:0] PCL_REG_STATUS = 8'h04;
   localparam logic [7:0] PCL_REG_IMG0 = 8'h10;
   localparam logic [7:0] PCL_REG_IMG1 = 8'h14;
   localparam logic [7:0] PCL_REG_IMG2 = 8'h18;
   localparam logic [7:0] PCL_REG_IMG3 = 8'h1c;
   localparam int PCL_CTRL_SKIP_LSB = 0;
   localparam int PCL_CTRL_RELOAD_BIT = 8;
   localparam int PCL_STAT_BUSY_BIT = 0;
   localparam int PCL_STAT_READY_BIT = 1;
   localparam int PCL_STAT_ABSENT_LSB = 8;
   localparam int PCL_STAT_TMO_LSB = 16;
   localparam logic [15:0] PCL_IMG_RST = 16'h0000;

   typedef enum logic [1:0] {
      PCL_LD_FETCH,
      PCL_LD_READY
   } pcl_ld_t;

endpackage

// ---- tb/pcl_loader_asserts.sv ----
// Checker for the port configuration word loader, watching top ports only.
// Assumes it is bound onto the loader top; one clock domain, clock enable held high.
`timescale 1ns/1ps
module pcl_loader_asserts (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic o_mem_req,
   input wire logic [7:0] o_mem_addr,
   input wire logic i_mem_ack,
   input wire logic i_mem_absent,
   input wire logic [15:0] i_mem_data,
   input wire logic o_wb_ack,
   input wire logic o_cfg_ready,
   input wire logic [1:0] o_no_soft_reset,
   input wire logic [15:0] o_pm_data,
   input wire logic o_slot_implemented,
   input wire logic [13:0] o_tc_vc0_map
);
   default clocking dc @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);
   logic tk;
   // A word that really lands in the port images
   assign tk = o_mem_req && i_mem_ack && !i_mem_absent;
   a_nsr_load: assert property (tk && o_mem_addr == 8'h54 |=>
      o_no_soft_reset[0] == $past(i_mem_data[0])) else $error("keep-state bit wrong");
   a_pmd_load: assert property (tk && o_mem_addr == 8'h55 |=>
      o_pm_data[7:0] == $past(i_mem_data[15:8])) else $error("power data byte wrong");
   a_tc_load: assert property (tk && o_mem_addr == 8'h60 |=>
      o_tc_vc0_map[6:0] == $past(i_mem_data[15:9])) else $error("class map wrong");
   a_slot_load: assert property (tk && o_mem_addr == 8'h62 |=>
      o_slot_implemented == $past(i_mem_data[0])) else $error("slot bit wrong");
   a_slot_hold: assert property (!tk |=> $stable(o_slot_implemented))
      else $error("slot bit moved without a word");
   a_addr_hold: assert property (o_mem_req && !i_mem_ack |=>
      !o_mem_req || $stable(o_mem_addr)) else $error("word address moved");
   a_req_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
      else $error("fetch request held after answer");
   a_load_quiet: assert property (o_mem_req |-> !o_cfg_ready)
      else $error("ready while loading");
   a_ack_gate: assert property (o_wb_ack |-> $past(o_cfg_ready) ##1 !o_wb_ack)
      else $error("bus answer before load or too long");
endmodule

// ---- tb/pcl_store_model.sv ----
// Behavioural word store answering the loader's fetches.
// Assumes fetches on the core clock; answers at once or after three waits.
`timescale 1ns/1ps
module pcl_store_model (
   input wire logic i_clk_sys,
   input wire logic i_req,
   input wire logic [7:0] i_addr,
   input wire logic i_slow,
   input wire logic [5:0][15:0] i_words,
   output logic o_ack,
   output logic o_absent,
   output logic [15:0] o_data
);
   logic [1:0] wait_cnt = 2'h0;
   logic hit;
   logic [2:0] idx;
   assign hit = i_addr inside {8'h54, 8'h55, 8'h56, 8'h57, 8'h60, 8'h62};
   // 60h/62h are entries 4/5; 54h..57h are entries 0..3
   assign idx = i_addr[5] ? {2'h2, i_addr[1]} : {1'b0, i_addr[1:0]};
   initial begin
      o_ack = 1'b0;
      o_absent = 1'b0;
      o_data = 16'h0;
   end
   always @(posedge i_clk_sys) begin
      o_ack <= 1'b0;
      // Data toggles when idle so no stale word can pass for a fresh one
      o_data <= ~o_data;
      if (i_req && !o_ack) begin
         if (wait_cnt >= (i_slow ? 2'h3 : 2'h0)) begin
            o_ack <= 1'b1;
            o_absent <= !hit;
            o_data <= hit ? i_words[idx] : ~o_data;
            wait_cnt <= 2'h0;
         end else begin
            wait_cnt <= wait_cnt + 2'h1;
         end
      end
   end
endmodule

// ---- tb/pcl_port_config_word_loader_tb.sv ----
// Self-checking bench for the port configuration word loader.
// Assumes the store model and the checker are compiled before this file.
`timescale 1ns/1ps
module pcl_port_config_word_loader_tb;
   import pcl_pkg::*;
   logic i_clk_sys = 0, i_sys_rst = 1, i_clk_en = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
   logic slow = 0, o_mem_req, i_mem_ack, i_mem_absent, o_wb_ack, o_cfg_ready;
   logic [7:0] i_wb_adr = 8'h00, o_mem_addr;
   logic [3:0] i_wb_sel = 4'h3, o_pme_support;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
   logic [15:0] i_mem_data, o_pm_data;
   logic [1:0] o_no_soft_reset, o_d1_support, o_d2_support, o_slot_clock_cfg;
   logic [1:0] o_dsi_required, o_low_priority_channel_count;
   logic [5:0] o_aux_current, o_port_number;
   logic [13:0] o_tc_vc0_map;
   logic o_slot_implemented;
   logic [5:0][15:0] m, e;
   logic [31:0] q[$];
   int failures = 0, samples_checked = 0, seed = 3, cycles = 0;
   always #50 i_clk_sys = ~i_clk_sys;
   pcl_port_config_word_loader #(.P_ACK_WAIT_CYC(8)) dut_u (.*);
   pcl_store_model store_u (.i_clk_sys(i_clk_sys), .i_req(o_mem_req), .i_addr(o_mem_addr),
      .i_slow(slow), .i_words(m), .o_ack(i_mem_ack), .o_absent(i_mem_absent),
      .o_data(i_mem_data));
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic report_and_stop;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Read data is judged mid-cycle while ack stands, clear of the launching edge
   always @(negedge i_clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop;
      end
      if (o_wb_ack === 1'b1 && !i_wb_we) chk("rdata", q.pop_front(), o_wb_dat);
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      if (!w) q.push_back(d);
      @(negedge i_clk_sys);
      while (o_wb_ack !== 1'b1) @(negedge i_clk_sys);
      // Release only after the edge that samples ack high
      @(posedge i_clk_sys);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask
   task automatic fields;
      chk("nsr", {e[2][0], e[0][0]}, o_no_soft_reset);
      chk("aux", {e[2][3:1], e[0][3:1]}, o_aux_current);
      chk("d1", {e[2][4], e[0][4]}, o_d1_support);
      chk("d2", {e[2][5], e[0][5]}, o_d2_support);
      chk("pme", {e[2][7:6], e[0][7:6]}, o_pme_support);
      chk("pmd", {e[3][15:8], e[1][15:8]}, o_pm_data);
      chk("clk", {e[5][1], e[4][1]}, o_slot_clock_cfg);
      chk("dsi", {e[5][2], e[4][2]}, o_dsi_required);
      chk("lpc", {e[5][3], e[4][3]}, o_low_priority_channel_count);
      chk("pnum", {e[5][6:4], e[4][6:4]}, o_port_number);
      chk("tc", {e[5][15:9], e[4][15:9]}, o_tc_vc0_map);
      chk("slot", e[5][0], o_slot_implemented);
   endtask
   initial begin
      logic [5:0] sk;
      logic [15:0] n;
      sk = 6'h00;
      for (int i = 0; i < 6; i++) begin
         n = $random(seed);
         m[i] = n;
         e[i] = n;
      end
      repeat (3) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      // Status read raised during the load must wait for it
      wb(1'b0, PCL_REG_STATUS, 32'h2);
      for (int it = 0; it < 3; it++) begin
         while (o_cfg_ready !== 1'b1) @(posedge i_clk_sys);
         fields;
         wb(1'b0, PCL_REG_CTRL, {26'h0, sk});
         wb(1'b0, PCL_REG_IMG0, {16'h0, e[4] & 16'hfe7e});
         wb(1'b0, PCL_REG_IMG1, {16'h0, e[5] & 16'hfe7f});
         wb(1'b0, PCL_REG_IMG2, {16'h0, e[1][15:8], e[0][7:0]});
         wb(1'b0, PCL_REG_IMG3, {16'h0, e[3][15:8], e[2][7:0]});
         wb(1'b0, 8'h40, 32'h0);
         if (it == 2) break;
         // Skipped entries must keep the values of the earlier load
         sk = (it == 0) ? 6'h01 : 6'h24;
         slow <= 1'b1;
         for (int i = 0; i < 6; i++) begin
            n = $random(seed);
            m[i] <= n;
            if (!sk[i]) e[i] = n;
         end
         wb(1'b1, PCL_REG_CTRL, {23'h0, 1'b1, 2'h0, sk});
         repeat (2) @(posedge i_clk_sys);
      end
      report_and_stop;
   end
endmodule
bind pcl_port_config_word_loader pcl_loader_asserts chk_u (.*);
